// ### bip_boot_mem.sv
/*
 * Behavioural boot memory that streams one image block as bytes.
 * Assumes the bench fills mem and len, then pulses go.
 */
module bip_boot_mem (
	input wire logic mclk,
	input wire logic byteReady,
	input wire logic slow,
	input wire logic go,
	input wire logic [15:0] len,
	output logic byteValid,
	output logic [7:0] byteData,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:255];

	// ==========================================================
	// Byte streaming
	initial begin
		byteValid = 1'b0;
		byteData = 8'h00;
		busy = 1'b0;
	end

	// Hold each byte until taken; idle data shows the inverse
	always @(posedge go) begin
		busy = 1'b1;
		for (int i = 0; i < len; i++) begin
			byteValid = 1'b1;
			byteData = mem[i];
			do @(posedge mclk); while (!byteReady);
			@(negedge mclk);
			if (slow) begin
				byteValid = 1'b0;
				byteData = ~byteData;
				@(negedge mclk);
			end
		end
		if (!slow) begin
			byteValid = 1'b0;
			byteData = ~byteData;
		end
		busy = 1'b0;
	end
endmodule : bip_boot_mem

// ### bip_parser.sv
/*
 * Word FIFO and boot image block parser top.
 * Assumes bytes come from the serial master on the same clock.
 */
// How it works
// - MCU words are four bytes, low byte first, from block byte 12.
// - Trailer holds zero bytes then checksum high, then checksum low.
// - Checksum covers block bytes 2 through N + 11, compared at trailer.
// - Coefficient words keep only bits 27 down to 0.
// - Coefficient bytes low first; fourth byte gives bits 27 to 24.
// - DSP data words are six bytes, first byte in bits 7 to 0.
// - Sixth data byte fills bits 47 to 40; words every six bytes.
// - Header ID other than 0x001F ends the whole load.
// - Memory select byte picks target: 0, 1, 3 or 4 handled.
// - Image ends with a termination block whose last 16 bytes are zero.

module bip_fifo
	import bip_pkg::*;
#(
	parameter int WIDTH = 72,
	parameter int DEPTH = 16,
	localparam int AW = $clog2(DEPTH)
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	output logic [AW:0] level
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] next_level;
	wire push = inValid && inReady;
	wire load = (level != '0) && (!outValid || outReady);

	// ==========================================================
	// Fill state
	assign inReady = level != (AW + 1)'(DEPTH);
	assign next_level = level + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
	// Storage write
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// Pointers and output register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wrPtr <= '0;
			rdPtr <= '0;
			level <= '0;
			outValid <= 1'b0;
			outData <= '0;
		end else begin
			level <= next_level;
			if (push) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (load) begin
				rdPtr <= rdPtr + 1'b1;
				outData <= mem[rdPtr];
				outValid <= 1'b1;
			end else if (outReady) begin
				outValid <= 1'b0;
			end
		end
	end
endmodule : bip_fifo

module bip_parser
	import bip_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	output logic byteReady,
	output logic wordValid,
	input wire logic wordReady,
	output bip_word_s word,
	output logic blockOk,
	output logic blockErr,
	output logic loadDone,
	output logic loadAbort
);
	// Bytes per memory word for a select code
	function automatic logic [2:0] wordLenOf(input logic [7:0] s);
		return (s == SEL_DSP_DATA) ? LEN_WORD6 : LEN_WORD4;
	endfunction : wordLenOf
	// Select codes this parser can load
	function automatic logic selKnown(input logic [7:0] s);
		return s == SEL_MCU_PROG || s == SEL_MCU_DATA ||
			s == SEL_DSP_COEF || s == SEL_DSP_DATA;
	endfunction : selKnown

	bip_state_e state;
	bip_state_e next_state;
	logic [15:0] idx;
	logic [15:0] total;
	logic [15:0] addr;
	logic [15:0] csum;
	logic [7:0] sel;
	logic [7:0] id0;
	logic [7:0] chkHi;
	logic [2:0] pos;
	logic [47:0] asm;
	logic trlBad;
	logic hdrBad;
	logic fifoInReady;
	logic [4:0] fifoLevel;

	// ==========================================================
	// Decode of the current byte
	wire take = byteValid && byteReady;
	wire [2:0] wLen = wordLenOf(sel);
	wire [15:0] trlLen = {13'h0000, wLen};
	wire [15:0] dataEnd = total - trlLen;
	wire [15:0] minTotal = HDR_LEN + trlLen;
	wire lastByte = idx == total - 16'h0001;
	wire trlZeroPos = idx < total - 16'h0002;
	wire [5:0] shAmt = {pos, 3'b000};
	wire [47:0] merged = asm | ({40'h0, byteData} << shAmt);
	wire isCoef = sel == SEL_DSP_COEF;
	wire [47:0] pushData = isCoef ? (merged & COEF_MASK) : merged;
	wire push = take && state == ST_DATA && pos == wLen - 3'h1;
	wire sumByte = idx >= CSUM_FIRST &&
		(state == ST_HDR || state == ST_DATA);
	wire [15:0] sumNext = csum + {8'h00, byteData};
	wire idBad = idx == IDX_ID1 && {id0, byteData} != ID_VALUE;
	wire chkGood = !trlBad && {chkHi, byteData} == csum;
	wire hdrEnd = state == ST_HDR && idx == IDX_HDR_LAST;
	wire tooShort = total < minTotal;
	wire abortNow = state == ST_HDR && (idBad || (hdrEnd && total != 16'h0000
		&& selKnown(sel) && tooShort));
	wire blockEnd = take && lastByte && (state == ST_TRL || state == ST_SKIP);
	wire trlEnd = take && state == ST_TRL && lastByte;
	wire termEnd = take && state == ST_TERM && idx == TERM_LAST;
	wire nonZero = byteData != 8'h00;
	bip_word_s pushWord;
	assign pushWord = '{memSel: sel, addr: addr, data: pushData};

	// ==========================================================
	// Block sequencing
	always_comb begin
		next_state = state;
		if (take) begin
			case (state)
				ST_HDR: begin
					if (abortNow) begin
						next_state = ST_DONE;
					end else if (hdrEnd) begin
						if (total == 16'h0000) begin
							next_state = ST_TERM;
						end else if (!selKnown(sel)) begin
							next_state = ST_SKIP;
						end else if (total == minTotal) begin
							next_state = ST_TRL;
						end else begin
							next_state = ST_DATA;
						end
					end
				end
				ST_DATA: begin
					if (idx == dataEnd - 16'h0001) begin
						next_state = ST_TRL;
					end
				end
				ST_TRL, ST_SKIP: begin
					if (lastByte) begin
						next_state = ST_HDR;
					end
				end
				ST_TERM: begin
					if (idx == TERM_LAST) begin
						next_state = ST_DONE;
					end
				end
				ST_DONE: next_state = ST_DONE;
				default: next_state = ST_HDR;
			endcase
		end
	end

	// Byte counter, checksum and header fields
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state <= ST_HDR;
			idx <= '0;
			csum <= '0;
			sel <= '0;
			id0 <= '0;
			total <= '0;
			addr <= '0;
		end else begin
			state <= next_state;
			if (take) begin
				idx <= blockEnd ? 16'h0000 : idx + 16'h0001;
				if (blockEnd) begin
					csum <= '0;
				end else if (sumByte) begin
					csum <= sumNext;
				end
				if (state == ST_HDR && idx == IDX_ID0) id0 <= byteData;
				if (state == ST_HDR && idx == IDX_SEL) sel <= byteData;
				if (state == ST_HDR && idx == IDX_ADR_HI) addr[15:8] <= byteData;
				if (state == ST_HDR && idx == IDX_ADR_LO) addr[7:0] <= byteData;
				if (state == ST_HDR && idx == IDX_TOT_HI) total[15:8] <= byteData;
				if (state == ST_HDR && idx == IDX_TOT_LO) total[7:0] <= byteData;
				if (push) addr <= addr + 16'h0001;
			end
		end
	end

	// Word assembly, low byte first; cleared outside data so no cut word leaks
	always_ff @(posedge mclk) begin
		if (!rst_b || state != ST_DATA) begin
			pos <= '0;
			asm <= '0;
		end else if (take) begin
			pos <= push ? 3'h0 : pos + 3'h1;
			asm <= push ? 48'h0 : merged;
		end
	end

	// Trailer and termination checks
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			trlBad <= 1'b0;
			hdrBad <= 1'b0;
			chkHi <= '0;
		end else if (take) begin
			if (blockEnd) begin
				trlBad <= 1'b0;
				hdrBad <= 1'b0;
			end else begin
				if (state == ST_TRL && trlZeroPos && nonZero) trlBad <= 1'b1;
				if ((state == ST_HDR && idx >= IDX_SEL) || state == ST_TERM) begin
					hdrBad <= hdrBad | nonZero;
				end
			end
			if (state == ST_TRL && idx == total - 16'h0002) chkHi <= byteData;
		end
	end

	// Status outputs and byte flow control
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			blockOk <= 1'b0;
			blockErr <= 1'b0;
			loadDone <= 1'b0;
			loadAbort <= 1'b0;
			byteReady <= 1'b0;
		end else begin
			blockOk <= trlEnd && chkGood;
			blockErr <= (trlEnd && !chkGood) || (blockEnd && state == ST_SKIP)
				|| (termEnd && (hdrBad || nonZero));
			loadDone <= next_state == ST_DONE;
			loadAbort <= loadAbort | (take && abortNow);
			byteReady <= next_state != ST_DONE && fifoInReady &&
				fifoLevel < LEVEL_LIMIT;
		end
	end

	// ==========================================================
	// Word buffer toward the memory writer
	bip_fifo #(.WIDTH($bits(bip_word_s)), .DEPTH(FIFO_DEPTH)) uFifo (
		.mclk(mclk),
		.rst_b(rst_b),
		.inValid(push),
		.inReady(fifoInReady),
		.inData(pushWord),
		.outValid(wordValid),
		.outReady(wordReady),
		.outData(word),
		.level(fifoLevel)
	);

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	property p_mcu_width;
		push && !isCoef && sel != SEL_DSP_DATA |-> pushData[47:32] == 16'h0;
	endproperty
	a_mcu_width: assert property (p_mcu_width) else $error("MCU word too wide");
	property p_coef_mask;
		push && isCoef |-> pushData[47:28] == 20'h0;
	endproperty
	a_coef_mask: assert property (p_coef_mask) else $error("coef unmasked");
	property p_coef_top;
		push && isCoef |-> pushData[27:24] == byteData[3:0] && pos == 3'h3;
	endproperty
	a_coef_top: assert property (p_coef_top) else $error("coef byte 4");
	property p_data_top;
		push && sel == SEL_DSP_DATA |-> pushData[47:40] == byteData && pos == 3'h5;
	endproperty
	a_data_top: assert property (p_data_top) else $error("data byte 6");
	property p_data_low;
		take && state == ST_DATA && pos == 3'h0 && !push |=> asm[7:0] == $past(byteData);
	endproperty
	a_data_low: assert property (p_data_low) else $error("first byte lost");
	property p_sum_ok;
		trlEnd && !trlBad && {chkHi, byteData} == csum |=> blockOk && !blockErr;
	endproperty
	a_sum_ok: assert property (p_sum_ok) else $error("good block refused");
	property p_sum_bad;
		trlEnd && {chkHi, byteData} != csum |=> blockErr && !blockOk;
	endproperty
	a_sum_bad: assert property (p_sum_bad) else $error("bad sum missed");
	property p_trl_zero;
		take && state == ST_TRL && trlZeroPos && nonZero |=> trlBad || state == ST_HDR;
	endproperty
	a_trl_zero: assert property (p_trl_zero) else $error("trailer zero");
	property p_id_abort;
		take && state == ST_HDR && idBad |=> loadDone && loadAbort ##1 !byteReady;
	endproperty
	a_id_abort: assert property (p_id_abort) else $error("bad ID kept on");
	property p_sel_known;
		state == ST_DATA |-> selKnown(sel);
	endproperty
	a_sel_known: assert property (p_sel_known) else $error("bad select");
	property p_term_done;
		termEnd |=> loadDone ##1 (loadDone && !byteReady);
	endproperty
	a_term_done: assert property (p_term_done) else $error("no load end");

	c_coef: cover property (push && isCoef);
	c_block_ok: cover property (blockOk);
	c_term: cover property (loadDone && !loadAbort);
	c_full: cover property (!fifoInReady);
endmodule : bip_parser

// ### bip_parser_tb.sv
/*
 * Self-checking bench of the boot image block parser.
 * Assumes bip_boot_mem as the byte source.
 */
module bip_parser_tb
	import bip_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic wordReady = 1'b0;
	logic slow = 1'b0;
	logic go = 1'b0;
	logic [15:0] len = 16'h0000;
	logic byteValid, byteReady, wordValid, busy;
	logic blockOk, blockErr, loadDone, loadAbort;
	logic [7:0] byteData;
	bip_word_s word;
	bip_word_s got[$];
	int fails = 0;
	int total_checks = 0;
	int okCnt = 0;
	int errCnt = 0;

	// ==========================================================
	// Clock, instances and monitor
	always #5 mclk = ~mclk;

	bip_parser dut (.mclk(mclk), .rst_b(rst_b), .byteValid(byteValid),
		.byteData(byteData), .byteReady(byteReady), .wordValid(wordValid),
		.wordReady(wordReady), .word(word), .blockOk(blockOk),
		.blockErr(blockErr), .loadDone(loadDone), .loadAbort(loadAbort));

	bip_boot_mem mem (.mclk(mclk), .byteReady(byteReady), .slow(slow),
		.go(go), .len(len), .byteValid(byteValid), .byteData(byteData),
		.busy(busy));

	// Collect taken words and status pulses
	always @(posedge mclk) begin
		if (wordValid === 1'b1 && wordReady) got.push_back(word);
		if (blockOk === 1'b1) okCnt++;
		if (blockErr === 1'b1) errCnt++;
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [71:0] seen, input logic [71:0] want);
		total_checks++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done

	task automatic do_reset;
		rst_b = 1'b0;
		repeat (8) @(negedge mclk);
		rst_b = 1'b1;
	endtask : do_reset

	// Build a block image with sum over bytes 2 to N + 11
	task automatic build(input logic [7:0] sel, input int nw, input int wl,
		input logic bad);
		logic [15:0] t;
		logic [15:0] sum;
		t = 16'(12 + nw * wl + wl);
		for (int i = 0; i < 12; i++) mem.mem[i] = 8'h00;
		mem.mem[3] = 8'h1f;
		mem.mem[4] = sel;
		mem.mem[6] = 8'h12;
		mem.mem[7] = 8'hfe;
		mem.mem[8] = t[15:8];
		mem.mem[9] = t[7:0];
		for (int i = 0; i < nw * wl; i++) mem.mem[12 + i] = 8'(i * 37 + 5);
		sum = 16'h0000;
		for (int i = 2; i < 12 + nw * wl; i++) sum += 16'(mem.mem[i]);
		for (int i = t - wl; i < t - 2; i++) mem.mem[i] = 8'h00;
		mem.mem[t - 2] = sum[15:8];
		mem.mem[t - 1] = sum[7:0] ^ {7'h00, bad};
		len = t;
		got.delete();
		okCnt = 0;
		errCnt = 0;
	endtask : build

	task automatic send(input int drain);
		go = 1'b1;
		@(negedge mclk);
		go = 1'b0;
		for (int i = 0; i < 400 && busy; i++) @(negedge mclk);
		repeat (drain) @(negedge mclk);
	endtask : send

	// Compare taken words with LSB-first assembly
	task automatic cmp_words(input logic [7:0] sel, input int nw, input int wl);
		logic [47:0] d;
		check(72'(got.size()), 72'(nw));
		for (int k = 0; k < nw && k < got.size(); k++) begin
			d = 48'h0;
			for (int b = 0; b < wl; b++) d[8 * b +: 8] = mem.mem[12 + k * wl + b];
			if (sel == SEL_DSP_COEF) d &= COEF_MASK;
			check(got[k], {sel, 16'h12fe + 16'(k), d});
		end
	endtask : cmp_words

	// ==========================================================
	// Scenarios
	task automatic t_formats;
		logic [7:0] sels [4] = '{SEL_MCU_PROG, SEL_MCU_DATA, SEL_DSP_COEF,
			SEL_DSP_DATA};
		int wl;
		wordReady = 1'b1;
		foreach (sels[s]) begin
			wl = (sels[s] == SEL_DSP_DATA) ? 6 : 4;
			build(sels[s], 3, wl, 1'b0);
			send(12);
			cmp_words(sels[s], 3, wl);
			check(72'(okCnt), 72'd1);
		end
	endtask : t_formats

	task automatic t_badsum;
		slow = 1'b1;
		build(SEL_DSP_DATA, 2, 6, 1'b1);
		send(12);
		check(72'({okCnt[3:0], errCnt[3:0]}), 72'h01);
		// Unsupported select is skipped whole and flagged
		build(8'h02, 1, 4, 1'b0);
		send(12);
		slow = 1'b0;
		check(72'({okCnt[3:0], errCnt[3:0]}), 72'h01);
		check(72'(got.size()), 72'd0);
	endtask : t_badsum

	// Stall the consumer until the parser drops byteReady
	task automatic t_stall;
		wordReady = 1'b0;
		build(SEL_DSP_COEF, 16, 4, 1'b0);
		go = 1'b1;
		@(negedge mclk);
		go = 1'b0;
		for (int i = 0; i < 300 && byteReady !== 1'b0; i++) @(negedge mclk);
		repeat (4) @(negedge mclk);
		check({byteReady, wordValid, 70'(got.size())}, {2'b01, 70'd0});
		wordReady = 1'b1;
		send(30);
		cmp_words(SEL_DSP_COEF, 16, 4);
		check(72'(okCnt), 72'd1);
	endtask : t_stall

	task automatic t_term;
		for (int i = 0; i < 20; i++) mem.mem[i] = 8'h00;
		mem.mem[3] = 8'h1f;
		len = 16'd20;
		errCnt = 0;
		send(4);
		check({loadDone, loadAbort, byteReady}, 3'b100);
		check(72'(errCnt), 72'd0);
	endtask : t_term

	task automatic t_badid;
		do_reset();
		build(SEL_MCU_PROG, 1, 4, 1'b0);
		mem.mem[3] = 8'h20;
		len = 16'd4;
		send(3);
		check({loadDone, loadAbort, byteReady}, 3'b110);
		// Total shorter than header plus trailer ends the load
		do_reset();
		build(SEL_MCU_PROG, 1, 4, 1'b0);
		mem.mem[9] = 8'h0a;
		len = 16'd12;
		send(3);
		check({loadDone, loadAbort, byteReady}, 3'b110);
		// Termination block with a stray nonzero byte is flagged
		do_reset();
		build(SEL_MCU_PROG, 1, 4, 1'b0);
		for (int i = 4; i < 20; i++) mem.mem[i] = 8'h00;
		mem.mem[15] = 8'h01;
		send(4);
		check({loadDone, loadAbort, errCnt[3:0]}, 6'h21);
	endtask : t_badid

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		do_reset();
		t_formats();
		t_badsum();
		t_stall();
		t_term();
		t_badid();
		test_done();
	end

	initial begin
		#100000;
		fails++;
		test_done();
	end
endmodule : bip_parser_tb

// ### bip_pkg.sv
/*
 * Shared constants and types of the boot image block parser.
 * Assumes one clock domain and a byte stream already deserialised.
 */
package bip_pkg;

	// ==========================================================
	// Block layout
	localparam int FIFO_DEPTH = 16;
	localparam logic [15:0] HDR_LEN = 16'h000c;
	localparam logic [15:0] CSUM_FIRST = 16'h0002;
	localparam logic [15:0] IDX_ID0 = 16'h0002;
	localparam logic [15:0] IDX_ID1 = 16'h0003;
	localparam logic [15:0] IDX_SEL = 16'h0004;
	localparam logic [15:0] IDX_ADR_HI = 16'h0006;
	localparam logic [15:0] IDX_ADR_LO = 16'h0007;
	localparam logic [15:0] IDX_TOT_HI = 16'h0008;
	localparam logic [15:0] IDX_TOT_LO = 16'h0009;
	localparam logic [15:0] IDX_HDR_LAST = 16'h000b;
	localparam logic [15:0] TERM_LAST = 16'h0013;
	localparam logic [15:0] ID_VALUE = 16'h001f;

	// ==========================================================
	// Memory select codes and word sizes
	localparam logic [7:0] SEL_MCU_PROG = 8'h00;
	localparam logic [7:0] SEL_MCU_DATA = 8'h01;
	localparam logic [7:0] SEL_DSP_COEF = 8'h03;
	localparam logic [7:0] SEL_DSP_DATA = 8'h04;
	localparam logic [2:0] LEN_WORD4 = 3'h4;
	localparam logic [2:0] LEN_WORD6 = 3'h6;
	localparam logic [47:0] COEF_MASK = 48'h0000_0fff_ffff;
	localparam logic [4:0] LEVEL_LIMIT = 5'h0e;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		ST_HDR = 3'b000,
		ST_DATA = 3'b001,
		ST_TRL = 3'b010,
		ST_TERM = 3'b011,
		ST_SKIP = 3'b100,
		ST_DONE = 3'b101
	} bip_state_e;

	typedef struct packed {
		logic [7:0] memSel;
		logic [15:0] addr;
		logic [47:0] data;
	} bip_word_s;

endpackage : bip_pkg
